/* verilog/amf_pkg.sv */
// Constants shared by the ASCII message framer
`default_nettype none
package amf_pkg;
  // Clock and indicator timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int TERM_HOLD_MS  = 500;
  localparam int TERM_HOLD_CYC = CLK_HZ / 1000 * TERM_HOLD_MS;
  localparam int RX_HOLD_MS    = 20;
  localparam int RX_HOLD_CYC   = CLK_HZ / 1000 * RX_HOLD_MS;
  localparam int HOLD_W        = 24;

  // Message and pattern geometry
  localparam int MSG_MAX  = 8;
  localparam int LEN_W    = 4;
  localparam int NPAT     = 4;
  localparam logic [7:0] WILDCARD = 8'h2a;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_CLR  = 8'h08;
  localparam logic [7:0] A_IEN  = 8'h0c;
  localparam logic [7:0] A_ACC  = 8'h10;
  localparam logic [7:0] A_TRM  = 8'h30;
  localparam logic [7:0] A_PAT  = 8'h50;
  localparam logic [7:0] A_PLEN = 8'h70;
  localparam logic [7:0] A_SIG  = 8'h74;
  localparam logic [7:0] A_LEN  = 8'h78;
  localparam int TBL_WORDS = 8;

  // Control fields and reset value
  localparam int CTRL_EIGHT = 0;
  localparam int CTRL_EN    = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;

  // Event bits of status, clear and enable
  localparam int EV_RX   = 0;
  localparam int EV_TERM = 1;
  localparam int EV_PAT  = 2;
  localparam int EV_OVF  = 3;
  localparam int EV_N    = 4;

  // Bus responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : amf_pkg
`default_nettype wire

/* verilog/amf_matcher.sv */
// One data-path pattern comparator for a closed message
`timescale 1ns/1ps
`default_nettype none
module amf_matcher #(
  parameter int MSG_MAX = amf_pkg::MSG_MAX,
  parameter int LEN_W   = amf_pkg::LEN_W
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Closed message
  input  wire logic                   eval,
  input  wire logic [8*MSG_MAX-1:0]   msg,
  input  wire logic [LEN_W-1:0]       msg_len,
  // Pattern
  input  wire logic [8*MSG_MAX-1:0]   pat,
  input  wire logic [LEN_W-1:0]       pat_len,
  // Result
  output logic                        hit_q,
  output logic                        done_q
);
  logic eq;
  logic wild;

  always_comb begin
    eq = (msg_len == pat_len);
    for (int i = 0; i < MSG_MAX; i++) begin
      if (i < int'(msg_len) && msg[8*i +: 8] != pat[8*i +: 8]) begin
        eq = 1'b0;
      end
    end
  end

  // Lone wildcard takes every message
  assign wild = (pat_len == LEN_W'(1)) && (pat[7:0] == amf_pkg::WILDCARD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= eval;
      // Zero length disables the path
      hit_q  <= eval && (pat_len != '0) && (wild || eq);
    end
  end
endmodule : amf_matcher
`default_nettype wire

/* verilog/amf_framer.sv */
// Receive framer for one serial data port with AXI4-Lite registers
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module amf_framer #(
  parameter int TERM_HOLD_CYC = amf_pkg::TERM_HOLD_CYC,
  parameter int RX_HOLD_CYC   = amf_pkg::RX_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write
  input  wire logic [amf_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // AXI4-Lite read
  input  wire logic [amf_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // Received characters
  input  wire logic                        rx_valid,
  input  wire logic [7:0]                  rx_data,
  // Indicators and interrupt
  output logic                             rx_led,
  output logic                             term_led,
  output logic                             pattern_led,
  output logic                             irq
);
  localparam int MM = amf_pkg::MSG_MAX;
  localparam int LW = amf_pkg::LEN_W;
  localparam int NP = amf_pkg::NPAT;
  localparam int NE = amf_pkg::EV_N;
  localparam int HW = amf_pkg::HOLD_W;

  // Register state
  logic [1:0]         ctrl_q;
  logic [NE-1:0]      sts_q;
  logic [NE-1:0]      ien_q;
  logic [31:0]        acc_q  [amf_pkg::TBL_WORDS];
  logic [31:0]        trm_q  [amf_pkg::TBL_WORDS];
  logic [31:0]        pat_q  [2*NP];
  logic [4*NP-1:0]    plen_q;
  logic [NP-1:0]      sig_q;

  // Bus state
  logic [7:0]         aw_addr_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;
  logic               aw_have_q;
  logic               w_have_q;
  logic               wr_go;
  logic [5:0]         wi;
  logic [5:0]         ri;
  logic [5:0]         rt;
  logic [31:0]        plen_m;

  // Framing state
  logic [7:0]         msg_q     [MM];
  logic [7:0]         msg_d     [MM];
  logic [LW-1:0]      cnt_q;
  logic [LW-1:0]      cnt_d;
  logic [8*MM-1:0]    closed_q;
  logic [LW-1:0]      closed_len_q;
  logic               eval_q;
  logic [7:0]         ch;
  logic               acc;
  logic               trm;
  logic               take;
  logic               close;
  logic               room;
  logic [NE-1:0]      ev;
  logic [NE-1:0]      clr;
  logic [NP-1:0]      hit;
  logic [NP-1:0]      done;
  logic               pat_ev;

  // Indicator state
  logic [2:0]         ind_ev;
  logic [2:0]         ind_q;
  logic [HW-1:0]      hold_q [3];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Write channel: address and data taken in either order
  assign wr_go = aw_have_q && w_have_q && !bvalid;
  assign wi    = aw_addr_q[7:2];
  assign ri    = araddr[7:2];
  // Tables sit eight words apart, so one offset indexes all three
  assign rt    = ri - amf_pkg::A_ACC[7:2];
  assign plen_m = merge({16'h0000, plen_q}, w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= amf_pkg::RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
        aw_have_q <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_have_q <= 1'b1;
        wready   <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (wi > amf_pkg::A_LEN[7:2]) ? amf_pkg::RESP_ERR : amf_pkg::RESP_OK;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Writable registers; status, signalling and length are read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= amf_pkg::CTRL_RST;
      ien_q  <= '0;
      plen_q <= '0;
      for (int i = 0; i < amf_pkg::TBL_WORDS; i++) begin
        acc_q[i] <= 32'h0000_0000;
        trm_q[i] <= 32'h0000_0000;
        pat_q[i] <= 32'h0000_0000;
      end
    end else if (wr_go) begin
      if (aw_addr_q == amf_pkg::A_CTRL && w_strb_q[0]) begin
        ctrl_q <= w_data_q[1:0];
      end
      if (aw_addr_q == amf_pkg::A_IEN && w_strb_q[0]) begin
        ien_q <= w_data_q[NE-1:0];
      end
      if (aw_addr_q == amf_pkg::A_PLEN) begin
        plen_q <= plen_m[4*NP-1:0];
      end
      for (int i = 0; i < amf_pkg::TBL_WORDS; i++) begin
        if (wi == amf_pkg::A_ACC[7:2] + 6'(i)) begin
          acc_q[i] <= merge(acc_q[i], w_data_q, w_strb_q);
        end
        if (wi == amf_pkg::A_TRM[7:2] + 6'(i)) begin
          trm_q[i] <= merge(trm_q[i], w_data_q, w_strb_q);
        end
        if (wi == amf_pkg::A_PAT[7:2] + 6'(i)) begin
          pat_q[i] <= merge(pat_q[i], w_data_q, w_strb_q);
        end
      end
    end
  end

  // Clear register is write only, one bit per event
  assign clr = (wr_go && aw_addr_q == amf_pkg::A_CLR && w_strb_q[0]) ?
               w_data_q[NE-1:0] : '0;

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= amf_pkg::RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= amf_pkg::RESP_OK;
      rdata   <= 32'h0000_0000;
      if (ri >= amf_pkg::A_ACC[7:2] && ri < amf_pkg::A_TRM[7:2]) begin
        rdata <= acc_q[rt[2:0]];
      end else if (ri >= amf_pkg::A_TRM[7:2] && ri < amf_pkg::A_PAT[7:2]) begin
        rdata <= trm_q[rt[2:0]];
      end else if (ri >= amf_pkg::A_PAT[7:2] && ri < amf_pkg::A_PLEN[7:2]) begin
        rdata <= pat_q[rt[2:0]];
      end else begin
        unique case (araddr)
          amf_pkg::A_CTRL: rdata <= {30'h0, ctrl_q};
          amf_pkg::A_STAT: rdata <= {{(32-NE){1'b0}}, sts_q};
          amf_pkg::A_CLR:  rdata <= 32'h0000_0000;
          amf_pkg::A_IEN:  rdata <= {{(32-NE){1'b0}}, ien_q};
          amf_pkg::A_PLEN: rdata <= {{(32-4*NP){1'b0}}, plen_q};
          amf_pkg::A_SIG:  rdata <= {{(32-NP){1'b0}}, sig_q};
          amf_pkg::A_LEN:  rdata <= {{(32-LW){1'b0}}, closed_len_q};
          default:         rresp <= amf_pkg::RESP_ERR;
        endcase
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Seven-bit mode strips the top bit; eight-bit codes go to the tables whole
  assign ch    = ctrl_q[amf_pkg::CTRL_EIGHT] ? rx_data : {1'b0, rx_data[6:0]};
  assign acc   = acc_q[ch[7:5]][ch[4:0]];
  assign trm   = trm_q[ch[7:5]][ch[4:0]];
  assign take  = rx_valid && ctrl_q[amf_pkg::CTRL_EN];
  assign room  = (cnt_q < LW'(MM));
  // Lone terminator closes nothing unless accepted itself
  assign close = take && trm && (cnt_q != '0 || acc);

  // Only accepted characters are appended
  always_comb begin
    msg_d = msg_q;
    cnt_d = cnt_q;
    if (acc && room) begin
      msg_d[cnt_q[LW-2:0]] = ch;
      cnt_d = cnt_q + LW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q        <= '0;
      closed_q     <= '0;
      closed_len_q <= '0;
      eval_q       <= 1'b0;
      for (int i = 0; i < MM; i++) begin
        msg_q[i] <= 8'h00;
      end
    end else begin
      eval_q <= close;
      if (close) begin
        // Buffer empties; later accepted characters open the next message
        cnt_q        <= '0;
        closed_len_q <= cnt_d;
        for (int i = 0; i < MM; i++) begin
          closed_q[8*i +: 8] <= msg_d[i];
        end
      end else if (take) begin
        msg_q <= msg_d;
        cnt_q <= cnt_d;
      end
    end
  end

  // Four data-path comparators
  for (genvar p = 0; p < NP; p++) begin : g_path
    amf_matcher #(
      .MSG_MAX (MM),
      .LEN_W   (LW)
    ) u_match (
      .aclk    (aclk),
      .aresetn (aresetn),
      .eval    (eval_q),
      .msg     (closed_q),
      .msg_len (closed_len_q),
      .pat     ({pat_q[2*p+1], pat_q[2*p]}),
      .pat_len (plen_q[4*p +: 4]),
      .hit_q   (hit[p]),
      .done_q  (done[p])
    );
  end

  assign pat_ev = done[0] && (hit != '0);

  // Each triggered path flips its own signalling bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sig_q <= '0;
    end else if (done[0]) begin
      sig_q <= sig_q ^ hit;
    end
  end

  // Sticky events; a new event outranks a clear in the same cycle
  assign ev[amf_pkg::EV_RX]   = rx_valid;
  assign ev[amf_pkg::EV_TERM] = close;
  assign ev[amf_pkg::EV_PAT]  = pat_ev;
  assign ev[amf_pkg::EV_OVF]  = take && acc && !room;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= '0;
      irq   <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~clr) | ev;
      irq   <= ((sts_q & ~clr | ev) & ien_q) != '0;
    end
  end

  // Indicator stretchers, each reloaded by its event
  assign ind_ev = {pat_ev, close, rx_valid};

  for (genvar k = 0; k < 3; k++) begin : g_ind
    localparam int HOLD = (k == 0) ? RX_HOLD_CYC : TERM_HOLD_CYC;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hold_q[k] <= '0;
        ind_q[k]  <= 1'b0;
      end else if (ind_ev[k]) begin
        hold_q[k] <= HW'(HOLD - 1);
        ind_q[k]  <= 1'b1;
      end else if (hold_q[k] != '0) begin
        hold_q[k] <= hold_q[k] - HW'(1);
        ind_q[k]  <= 1'b1;
      end else begin
        ind_q[k]  <= 1'b0;
      end
    end
  end

  // Flop outputs, renamed only
  assign rx_led      = ind_q[0];
  assign term_led    = ind_q[1];
  assign pattern_led = ind_q[2];
endmodule : amf_framer
`default_nettype wire

/* testbench/amf_serial_dev.sv */
// Behavioural ASCII serial source feeding received characters to the framer
`timescale 1ns/1ps
`default_nettype none
module amf_serial_dev (
  // Clock
  input  wire logic       aclk,
  // Character stream
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end

  // Back-to-back pulses; idle data is inverted so a stale byte never looks fresh
  task automatic send(input logic [7:0] s[$]);
    foreach (s[i]) begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_data  <= s[i];
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask : send
endmodule : amf_serial_dev
`default_nettype wire

/* testbench/amf_framer_asserts.sv */
// Concurrent checks on the framer ports
`timescale 1ns/1ps
`default_nettype none
module amf_framer_asserts #(
  parameter int TERM_HOLD_CYC = 20,
  parameter int RX_HOLD_CYC   = 5
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // Stream and indicators
  input wire logic        rx_valid,
  input wire logic        rx_led,
  input wire logic        term_led,
  input wire logic        pattern_led,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Retriggers lengthen a run, so only a lower bound is checked
  int unsigned term_run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !term_led) term_run_q <= 0;
    else term_run_q <= term_run_q + 1;
  end

  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence

  chk_rx_flicker: assert property (rx_valid |=> rx_led[*5])
    else $error("rx light not stretched");
  chk_term_hold: assert property ($fell(term_led) |-> term_run_q >= TERM_HOLD_CYC)
    else $error("terminator light too short");
  chk_term_cause: assert property (
    $rose(term_led) |-> $past(rx_valid) || $past(rx_valid, 2))
    else $error("terminator light without a character");
  chk_pat_after: assert property ($rose(pattern_led) |-> term_led)
    else $error("pattern light without terminator");
  chk_wr_answer: assert property (wr_taken |-> ##[1:2] bvalid)
    else $error("write response missing");
  chk_ready_drop: assert property (wr_taken |=> !awready && !wready)
    else $error("write readies not dropped");
  chk_rd_answer: assert property (rd_taken |=> rvalid && !arready)
    else $error("read answer missing");
  chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  chk_reset_idle: assert property (
    $rose(aresetn) |-> awready && arready && !bvalid && !rvalid && !irq)
    else $error("outputs not idle after reset");
endmodule : amf_framer_asserts

bind amf_framer amf_framer_asserts #(
  .TERM_HOLD_CYC(TERM_HOLD_CYC),
  .RX_HOLD_CYC(RX_HOLD_CYC)
) chk_u (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rvalid, .rready, .rx_valid, .rx_led, .term_led,
  .pattern_led, .irq
);
`default_nettype wire

/* testbench/tb_ascii_message_framer.sv */
// Self-checking bench for the framer
`timescale 1ns/1ps
`default_nettype none
module tb_ascii_message_framer;
  localparam int HOLD_T = 20;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_led, term_led, pattern_led, irq;
  logic [amf_pkg::ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] rx_data;
  int n_fail, n_compared;
  // Configuring party's rack window and port range
  localparam int WIN_LO  = 1;
  localparam int WIN_HI  = 2047;
  localparam int N_PORTS = 4;

  amf_framer #(.TERM_HOLD_CYC(HOLD_T), .RX_HOLD_CYC(5)) dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .rx_valid, .rx_data, .rx_led, .term_led, .pattern_led, .irq);
  amf_serial_dev dev_u (.aclk, .rx_valid, .rx_data);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = amf_pkg::RESP_OK);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= !slow;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    if (slow) begin
      bready <= 1'b1;
      @(posedge aclk);
    end
    check(32'(bresp), 32'(er), "bresp");
    bready <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er = amf_pkg::RESP_OK);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= !slow;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    if (slow) begin
      rready <= 1'b1;
      @(posedge aclk);
    end
    check(rdata, e, "rdata");
    check(32'(rresp), 32'(er), "rresp");
    rready <= 1'b0;
  endtask : rd_chk

  task automatic t_bus;
    rd_chk(amf_pkg::A_CTRL, 32'h3);
    rd_chk(amf_pkg::A_STAT, 32'h0);
    slow = 1'b1;
    wr(amf_pkg::A_SIG, 32'hf);
    rd_chk(amf_pkg::A_SIG, 32'h0);
    slow = 1'b0;
    wr(8'h7c, 32'h1, amf_pkg::RESP_ERR);
    rd_chk(8'h7c, 32'h0, amf_pkg::RESP_ERR);
    $display("bus test done");
  endtask : t_bus

  task automatic t_frame;
    wr(amf_pkg::A_ACC + 8'h08, 32'h6);
    wr(amf_pkg::A_TRM, 32'h2000);
    wr(amf_pkg::A_PAT, 32'h4241);
    wr(amf_pkg::A_PAT + 8'h08, {24'h0, amf_pkg::WILDCARD});
    wr(amf_pkg::A_PLEN, 32'h12);
    wr(amf_pkg::A_IEN, 32'hf);
    rd_chk(amf_pkg::A_ACC + 8'h08, 32'h6);
    rd_chk(amf_pkg::A_PAT + 8'h08, 32'h2a);
    dev_u.send({8'h41, 8'h58, 8'h42, 8'h0d});
    repeat (3) @(posedge aclk);
    check(32'(rx_led), 32'h1, "rx light");
    check(32'(term_led), 32'h1, "term light");
    check(32'(pattern_led), 32'h1, "pattern light");
    check(32'(irq), 32'h1, "irq raised");
    rd_chk(amf_pkg::A_LEN, 32'h2);
    rd_chk(amf_pkg::A_SIG, 32'h3);
    rd_chk(amf_pkg::A_STAT, 32'h7);
    wr(amf_pkg::A_IEN, 32'h0);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0, "irq masked");
    wr(amf_pkg::A_IEN, 32'hf);
    wr(amf_pkg::A_CLR, 32'hf);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0, "irq cleared");
    rd_chk(amf_pkg::A_STAT, 32'h0);
    $display("frame test done");
  endtask : t_frame

  task automatic t_carry;
    dev_u.send({8'h41, 8'h0d, 8'h41, 8'h42, 8'h0d});
    repeat (3) @(posedge aclk);
    rd_chk(amf_pkg::A_LEN, 32'h2);
    rd_chk(amf_pkg::A_SIG, 32'h2);
    // Ninth accepted character finds the buffer full
    dev_u.send({8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h0d});
    repeat (3) @(posedge aclk);
    rd_chk(amf_pkg::A_LEN, 32'h8);
    rd_chk(amf_pkg::A_STAT, 32'hf);
    wr(amf_pkg::A_CLR, 32'hf);
    $display("carry test done");
  endtask : t_carry

  task automatic t_lone;
    repeat (HOLD_T + 4) @(posedge aclk);
    dev_u.send({8'hc1, 8'h0d});
    repeat (3) @(posedge aclk);
    check(32'(term_led), 32'h0, "lone terminator");
    wr(amf_pkg::A_ACC + 8'h18, 32'h2);
    dev_u.send({8'hc1, 8'h0d});
    repeat (3) @(posedge aclk);
    check(32'(term_led), 32'h1, "high code");
    rd_chk(amf_pkg::A_LEN, 32'h1);
    repeat (HOLD_T + 4) @(posedge aclk);
    wr(amf_pkg::A_ACC, 32'h2000);
    dev_u.send({8'h0d});
    repeat (3) @(posedge aclk);
    check(32'(term_led), 32'h1, "accepted terminator");
    $display("lone terminator test done");
  endtask : t_lone

  task automatic t_off;
    repeat (HOLD_T + 4) @(posedge aclk);
    wr(amf_pkg::A_CTRL, 32'h1);
    dev_u.send({8'h41, 8'h0d});
    @(posedge aclk);
    check(32'(rx_led), 32'h1, "rx while disabled");
    repeat (2) @(posedge aclk);
    check(32'(term_led), 32'h0, "no frame while disabled");
    // Seven-bit mode folds 0xc1 onto A and 0x8d onto the terminator
    wr(amf_pkg::A_CTRL, 32'h2);
    dev_u.send({8'hc1, 8'h8d});
    repeat (3) @(posedge aclk);
    rd_chk(amf_pkg::A_LEN, 32'h2);
    wr(amf_pkg::A_CTRL, 32'h3);
    $display("disabled test done");
  endtask : t_off

  // Configuring party keeps start registers inside the rack window
  function automatic int start_fix(input int base, input int start);
    if (start < base + WIN_LO) begin
      return base + WIN_LO;
    end
    if (start > base + WIN_HI) begin
      return base + WIN_HI;
    end
    return start;
  endfunction : start_fix

  function automatic logic port_ok(input int port);
    return port >= 1 && port <= N_PORTS;
  endfunction : port_ok

  task automatic t_cfg;
    check(32'(start_fix(32'h64, 32'h10)), 32'h65, "start below window");
    check(32'(start_fix(32'h64, 32'h900)), 32'h863, "start above window");
    check(32'(start_fix(32'h64, 32'h200)), 32'h200, "start inside window");
    check(32'(port_ok(0)), 32'h0, "port zero");
    check(32'(port_ok(1)), 32'h1, "port one");
    check(32'(port_ok(4)), 32'h1, "port four");
    check(32'(port_ok(5)), 32'h0, "port five");
    $display("configuration test done");
  endtask : t_cfg

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    n_fail = 0;
    n_compared = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_frame();
    t_carry();
    t_lone();
    t_off();
    t_cfg();
    complete_run();
  end
endmodule : tb_ascii_message_framer
`default_nettype wire
